// ---- tb/tlp_transmit_user_port_test.sv ----
// self-checking testbench of the transmit user port
`timescale 1ns/1ps
`default_nettype none
module tlp_transmit_user_port_test;
   import ttu_pkg::*;
   localparam int PACE = 3;
   logic              clk = 1'b0, rst = 1'b1, downgraded_x1 = 1'b0;
   logic              send_request, send_ready, send_beat_enable, link_beat_valid;
   logic              posted_credit_recheck, completion_credit_recheck, p_seen, c_seen;
   logic [63:0]       head = '0;
   logic [7:0]        beats = '0, null_at = '0, want = '0, sent;
   logic [2:0][8:0]   header_credits_avail;
   logic [2:0][12:0]  data_credits_avail;
   ttu_beat_type      app_beat, link_beat, last_beat;
   ttu_fc_update_type fc_update = '0;
   int                n_mismatch = 0, total_checks = 0, n_link, hc[3], dc[3];
   // *****
   // harness
   // *****
   initial forever #2.5 clk = ~clk;
   ttu_tx_user_port #(.PACE_RATIO(PACE)) i_dut (.clk, .rst, .downgraded_x1, .send_request,
      .packet_start_strobe(app_beat.start), .packet_end_strobe(app_beat.last),
      .packet_nullify(app_beat.nullify), .upper_half_only(app_beat.upper_half),
      .send_payload_bus(app_beat.data), .fc_update, .send_ready, .send_beat_enable,
      .header_credits_avail, .data_credits_avail, .posted_credit_recheck,
      .completion_credit_recheck, .link_beat, .link_beat_valid);
   ttu_app_model i_app (.clk, .head, .beats, .null_at, .want, .send_ready,
      .send_beat_enable, .send_request, .beat(app_beat), .sent);
   // sticky recheck flags and link beats
   // recheck prompts credit re-read
   always @(posedge clk) begin
      p_seen <= p_seen | posted_credit_recheck;
      c_seen <= c_seen | completion_credit_recheck;
      if (link_beat_valid === 1'b1) begin
         n_link <= n_link + 1;
         last_beat <= link_beat;
      end
   end
   task automatic check(logic [12:0] seen, logic [12:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic load(int c, int h, int d);
      @(negedge clk);
      fc_update <= '{1'b1, ttu_class_type'(c), 9'(h), 13'(d)};
      hc[c] = h;
      dc[c] = d;
      @(negedge clk);
      fc_update.valid <= 1'b0;
   endtask
   // send cnt packets of one class and compare with the credit model
   task automatic send(int c, int ty, int len, int nb, int na, int cnt);
      int w, oh, od, dw;
      head = {1'b0, 7'(ty), 14'h0, 10'(len), 32'h0};
      beats = 8'(nb);
      null_at = 8'(na);
      p_seen = 1'b0;
      c_seen = 1'b0;
      n_link = 0;
      oh = hc[c];
      od = dc[c];
      dw = len == 0 ? 1024 : len;
      @(posedge clk);
      want = want + 8'(cnt);
      for (w = 0; w < 900 && sent !== want; w++)
         @(negedge clk);
      repeat (3) @(negedge clk);
      if (na == 0)
         repeat (cnt) begin
            if (hc[c] < 256) hc[c] = hc[c] > 0 ? hc[c] - 1 : 0;
            if (ty[6] && dc[c] < 4096) dc[c] = dc[c] > (dw + 3) / 4 ? dc[c] - (dw + 3) / 4 : 0;
         end
      for (w = 0; w < 3; w++) begin
         check(13'(header_credits_avail[w]), 13'(hc[w]));
         check(data_credits_avail[w], 13'(dc[w]));
      end
      check(13'(p_seen), 13'(c == 0 && (oh != hc[c] || od != dc[c])));
      check(13'(c_seen), 13'(c == 2 && (oh != hc[c] || od != dc[c])));
      check(13'(n_link), 13'(cnt * (na ? na : nb)));
      check(13'({last_beat.nullify, last_beat.last}), 13'(na ? 2 : 1));
      check(13'({last_beat.upper_half, last_beat.data[11:0]}),
            13'({na == 0 || na == nb, 12'(na ? na - 1 : nb - 1)}));
   endtask
   task automatic final_report;
      if (n_mismatch == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog, far beyond eighteen short packets
   initial begin
      #100us;
      n_mismatch++;
      final_report;
   end
   // main sequence: posted, nonposted, completion, nullify, infinite, burst, pacing
   initial begin
      void'($urandom(32'h2D82));
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      check(13'(send_ready), 13'h0000);
      for (int i = 0; i < 3; i++)
         load(i, 9 + $urandom % 200, 20 + $urandom % 3000);
      for (int i = 0; i < 9; i++)
         send(i % 3, i % 3 == 0 ? 32'h40 : i % 3 == 1 ? 32'h0 : 32'h4A, $urandom % 1024,
              1 + $urandom % 4, 0, 1);
      send(0, 32'h40, 8, 3, 2, 1);
      send(2, 32'h4A, 8, 3, 1, 1);
      load(0, 32'h100, 32'h1000);
      send(0, 32'h40, 16, 2, 0, 1);
      load(2, 1, 2);
      send(2, 32'h4A, 0, 2, 0, 1);
      send(1, 32'h0, 4, 1, 0, 3);
      downgraded_x1 = 1'b1;
      send(2, 32'h4A, 12, 4, 0, 2);
      downgraded_x1 = 1'b0;
      final_report;
   end
endmodule
`default_nettype wire

// ---- tb/ttu_app_model.sv ----
// application model that frames packets into the transmit user port
`timescale 1ns/1ps
`default_nettype none
module ttu_app_model
   import ttu_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [63:0] head,
   input  wire logic [7:0]  beats,
   input  wire logic [7:0]  null_at,
   input  wire logic [7:0]  want,
   input  wire logic        send_ready,
   input  wire logic        send_beat_enable,
   output logic             send_request,
   output ttu_beat_type     beat,
   output logic [7:0]       sent
);
   int k = -3;
   initial beat = '0;
   initial sent = '0;
   initial send_request = 1'b0;
   // one step of the packet sequence per falling edge
   always @(negedge clk) begin
      if (k == -3 && sent < want)
         k = -2;
      if (k == -1)
         k = 0;
      // start goes out in the cycle after ready
      if (k == -2 && send_ready)
         k = -1;
      // gapless enabled beats, end or nullify closes
      if (k >= 0 && send_beat_enable) begin
         beat <= '{k == 0, k + 1 == beats && null_at == 0, k + 1 == null_at, k + 1 == beats,
                   k == 0 ? head : head ^ 64'(k)};
         k = (k + 1 == beats || k + 1 == null_at) ? -3 : k + 1;
         if (k == -3)
            sent <= sent + 8'h01;
      end else if (k < 0)
         beat <= '{1'b0, 1'b0, 1'b0, 1'b0, ~beat.data};
      // request level held through a burst
      send_request <= k != -3 || sent < want;
   end
endmodule
`default_nettype wire

// ---- tb/ttu_port_checker.sv ----
// assertions on the transmit user port outputs
`timescale 1ns/1ps
`default_nettype none
module ttu_port_checker
   import ttu_pkg::*;
#(
   parameter int PACE_RATIO = 4
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              downgraded_x1,
   input wire ttu_fc_update_type fc_update,
   input wire logic              send_ready,
   input wire logic              send_beat_enable,
   input wire logic [2:0][8:0]   header_credits_avail,
   input wire logic [2:0][12:0]  data_credits_avail,
   input wire logic              posted_credit_recheck,
   input wire logic              completion_credit_recheck,
   input wire ttu_beat_type      link_beat,
   input wire logic              link_beat_valid
);
   // *****
   // properties
   // *****
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   int gap;
   // cycles since the last pacing enable
   always_ff @(posedge clk)
      gap <= (rst || send_beat_enable || !downgraded_x1) ? 0 : gap + 1;
   ready_pulse_a: assert property (send_ready |=> !send_ready)
      else $error("ready held");
   gap_ready_a: assert property (link_beat_valid && (link_beat.last || link_beat.nullify)
      |-> !send_ready ##1 !send_ready) else $error("ready in gap");
   pace_gap_a: assert property (gap < PACE_RATIO) else $error("pacing gap long");
   pace_low_a: assert property (PACE_RATIO > 1 && downgraded_x1 && send_beat_enable
      |=> !send_beat_enable) else $error("pacing enable held");
   hdr_rise_a: assert property (!$past(fc_update.valid)
      |-> header_credits_avail[0] <= $past(header_credits_avail[0])) else $error("credit rose");
   hdr_inf_a: assert property (header_credits_avail[0][8] && !fc_update.valid
      |=> $stable(header_credits_avail[0])) else $error("infinite moved");
   data_inf_a: assert property (data_credits_avail[0][12] && !fc_update.valid
      |=> $stable(data_credits_avail[0])) else $error("infinite moved");
   p_recheck_a: assert property (posted_credit_recheck |->
      !$stable(header_credits_avail[0]) || !$stable(data_credits_avail[0])) else $error("p flag");
   c_recheck_a: assert property (completion_credit_recheck |->
      !$stable(header_credits_avail[2]) || !$stable(data_credits_avail[2])) else $error("c flag");
   null_free_a: assert property (link_beat_valid && link_beat.nullify && !$past(fc_update.valid)
      |-> $stable(header_credits_avail) && !posted_credit_recheck && !completion_credit_recheck)
      else $error("nullify spent");
   reset_clear_a: assert property (disable iff (1'b0) rst |=> !send_ready
      && send_beat_enable && !link_beat_valid && header_credits_avail == '0
      && data_credits_avail == '0) else $error("reset not cleared");
endmodule
bind ttu_tx_user_port ttu_port_checker #(.PACE_RATIO(PACE_RATIO)) i_check (.clk, .rst,
   .downgraded_x1, .fc_update, .send_ready, .send_beat_enable, .header_credits_avail,
   .data_credits_avail, .posted_credit_recheck, .completion_credit_recheck, .link_beat,
   .link_beat_valid);
`default_nettype wire

// ---- verilog/ttu_cfg.svh ----
// timing, reset and field constants of the transmit user port
`ifndef TTU_CFG_SVH
`define TTU_CFG_SVH

`define TTU_USER_CLK_MHZ       125
`define TTU_X1_PACE_RATIO      4
`define TTU_HDR_INF_BIT        8
`define TTU_DATA_INF_BIT       12
`define TTU_HDR_RESET          9'h000
`define TTU_DATA_RESET         13'h0000
`define TTU_FMT_HI             62
`define TTU_FMT_LO             61
`define TTU_TYPE_HI            60
`define TTU_TYPE_LO            56
`define TTU_LEN_HI             41
`define TTU_LEN_LO             32

`endif

// ---- verilog/ttu_pkg.sv ----
// types shared by the transmit user port
`default_nettype none

package ttu_pkg;

   // traffic class of a packet, also the index into the credit arrays
   typedef enum logic [1:0] {
      ttu_posted_type_e,
      ttu_nonposted_type_e,
      ttu_completion_type_e
   } ttu_class_type;

   // handshake states
   typedef enum logic [2:0] {
      ttu_idle,
      ttu_offer,
      ttu_armed,
      ttu_body,
      ttu_gap
   } ttu_state_type;

   // one beat of a packet
   typedef struct packed {
      logic        start;
      logic        last;
      logic        nullify;
      logic        upper_half;
      logic [63:0] data;
   } ttu_beat_type;

   // credit grant from a flow-control update
   typedef struct packed {
      logic          valid;
      ttu_class_type pkt_class;
      logic [8:0]    hdr;
      logic [12:0]   data;
   } ttu_fc_update_type;

endpackage

`default_nettype wire

// ---- verilog/ttu_tx_user_port.sv ----
// transmit user port: handshake, framing, pacing and credit tracking
//
// Notes on behaviour
// - request may stay high across burst
// - ready drops in gap between packets
// - nullify ends packet on any beat
// - pacing enable throttles downgraded x1
// - 9-bit header credits, bit 8 infinite
// - 13-bit data credits, bit 12 infinite
// - sends lower credits, updates overwrite them
// - posted send pulses posted recheck if a finite count moves
// - completion send pulses completion recheck if a finite count moves
// - everything on the 125 MHz user clock
// - reset clears datapath and state
`timescale 1ns/1ps
`include "ttu_cfg.svh"
`default_nettype none

module ttu_tx_user_port
   import ttu_pkg::*;
#(
   parameter int PACE_RATIO = `TTU_X1_PACE_RATIO
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              downgraded_x1,
   input  wire logic              send_request,
   input  wire logic              packet_start_strobe,
   input  wire logic              packet_end_strobe,
   input  wire logic              packet_nullify,
   input  wire logic              upper_half_only,
   input  wire logic [63:0]       send_payload_bus,
   input  wire ttu_fc_update_type fc_update,
   output logic                   send_ready,
   output logic                   send_beat_enable,
   output logic [2:0][8:0]        header_credits_avail,
   output logic [2:0][12:0]       data_credits_avail,
   output logic                   posted_credit_recheck,
   output logic                   completion_credit_recheck,
   output ttu_beat_type           link_beat,
   output logic                   link_beat_valid
);

   // ************************************************************
   // elaboration checks and helpers
   // ************************************************************

   localparam int PW = (PACE_RATIO > 1) ? $clog2(PACE_RATIO) : 1;

   if (PACE_RATIO < 1 || PACE_RATIO > 16) begin : g_bad_ratio
      $error("pace ratio out of range");
   end

   // class from the fmt/type fields of the first header beat
   function automatic ttu_class_type class_of(input logic [63:0] hdr);
      logic [1:0] fmt;
      logic [4:0] kind;
      fmt  = hdr[`TTU_FMT_HI:`TTU_FMT_LO];
      kind = hdr[`TTU_TYPE_HI:`TTU_TYPE_LO];
      if (kind[4:1] == 4'h5) begin
         class_of = ttu_completion_type_e;
      end else if ((kind == 5'h00 && fmt[1]) || kind[4:3] == 2'h2) begin
         class_of = ttu_posted_type_e;
      end else begin
         class_of = ttu_nonposted_type_e;
      end
   endfunction

   // data credits of a packet: one per four dwords, length 0 means 1024
   function automatic logic [11:0] data_units(input logic [63:0] hdr);
      logic [10:0] len;
      len = {hdr[`TTU_LEN_HI:`TTU_LEN_LO] == 10'h000, hdr[`TTU_LEN_HI:`TTU_LEN_LO]};
      if (!hdr[`TTU_FMT_LO + 1]) begin
         data_units = 12'h000;
      end else begin
         data_units = {3'h0, 9'((len + 11'h003) >> 2)};
      end
   endfunction

   // saturating subtract on the count field
   function automatic logic [11:0] take(input logic [11:0] have, input logic [11:0] used);
      take = (have > used) ? have - used : 12'h000;
   endfunction

   // ************************************************************
   // pacing for a downgraded core
   // ************************************************************

   logic [PW-1:0] pace_count;

   always_ff @(posedge clk) begin
      if (rst) begin
         pace_count       <= '0;
         send_beat_enable <= 1'b1;
      end else if (!downgraded_x1) begin
         pace_count       <= '0;
         send_beat_enable <= 1'b1;
      end else begin
         pace_count       <= (int'(pace_count) == PACE_RATIO - 1) ? '0 : pace_count + 1'b1;
         send_beat_enable <= (int'(pace_count) == PACE_RATIO - 1);
      end
   end

   // ************************************************************
   // handshake state machine
   // ************************************************************

   ttu_state_type state;
   ttu_state_type next_state;
   logic          beat_taken;
   logic          closes;

   assign beat_taken = send_beat_enable && (state == ttu_armed ? packet_start_strobe
                                                                : state == ttu_body);
   assign closes     = beat_taken && (packet_end_strobe || packet_nullify);

   // next state from request and framing strobes
   always_comb begin
      next_state = state;
      unique case (state)
         ttu_idle:  if (send_request) next_state = ttu_offer;
         ttu_offer: next_state = ttu_armed;
         ttu_armed: begin
            if (closes) begin
               next_state = ttu_gap;
            end else if (beat_taken) begin
               next_state = ttu_body;
            end else if (send_beat_enable) begin
               next_state = ttu_idle;     // no start came
            end
         end
         ttu_body:  if (closes) next_state = ttu_gap;
         ttu_gap:   next_state = ttu_idle;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ttu_idle;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         send_ready <= 1'b0;
      end else begin
         send_ready <= (next_state == ttu_offer);
      end
   end

   // ************************************************************
   // beat forwarding toward the link
   // ************************************************************

   always_ff @(posedge clk) begin
      if (rst) begin
         link_beat       <= '0;
         link_beat_valid <= 1'b0;
      end else begin
         link_beat_valid    <= beat_taken;
         link_beat.start    <= beat_taken && state == ttu_armed;
         link_beat.last     <= beat_taken && packet_end_strobe && !packet_nullify;
         link_beat.nullify  <= beat_taken && packet_nullify;
         link_beat.upper_half <= beat_taken && upper_half_only;
         link_beat.data     <= beat_taken ? send_payload_bus : 64'h0000000000000000;
      end
   end

   // ************************************************************
   // credit tracking
   // ************************************************************

   ttu_class_type pkt_class;
   logic [11:0]   pkt_units;
   logic          pkt_done;
   ttu_class_type done_class;
   logic [11:0]   done_units;

   // class and size caught on the start beat
   always_ff @(posedge clk) begin
      if (rst) begin
         pkt_class <= ttu_posted_type_e;
         pkt_units <= 12'h000;
      end else if (beat_taken && state == ttu_armed) begin
         pkt_class <= class_of(send_payload_bus);
         pkt_units <= data_units(send_payload_bus);
      end
   end

   assign done_class = (state == ttu_armed) ? class_of(send_payload_bus) : pkt_class;
   assign done_units = (state == ttu_armed) ? data_units(send_payload_bus) : pkt_units;
   assign pkt_done   = beat_taken && packet_end_strobe && !packet_nullify;

   always_ff @(posedge clk) begin
      logic [8:0]  h;
      logic [12:0] d;
      if (rst) begin
         header_credits_avail <= {3{`TTU_HDR_RESET}};
         data_credits_avail   <= {3{`TTU_DATA_RESET}};
      end else begin
         for (int c = 0; c < 3; c++) begin
            h = header_credits_avail[c];
            d = data_credits_avail[c];
            if (fc_update.valid && int'(fc_update.pkt_class) == c) begin
               h = fc_update.hdr;
               d = fc_update.data;
            end
            if (pkt_done && int'(done_class) == c) begin
               if (!h[`TTU_HDR_INF_BIT]) begin
                  h = {1'b0, 8'(take({4'h0, h[7:0]}, 12'h001))};
               end
               if (!d[`TTU_DATA_INF_BIT]) begin
                  d = {1'b0, take(d[11:0], done_units)};
               end
            end
            header_credits_avail[c] <= h;
            data_credits_avail[c]   <= d;
         end
      end
   end

   // ************************************************************
   // recheck pulses
   // ************************************************************

   logic counts_move;

   // a count moves only when finite and not already empty
   assign counts_move = (!header_credits_avail[done_class][`TTU_HDR_INF_BIT]
                         && header_credits_avail[done_class][7:0] != 8'h00)
                      || (!data_credits_avail[done_class][`TTU_DATA_INF_BIT]
                         && data_credits_avail[done_class][11:0] != 12'h000
                         && done_units != 12'h000);

   always_ff @(posedge clk) begin
      if (rst) begin
         posted_credit_recheck     <= 1'b0;
         completion_credit_recheck <= 1'b0;
      end else begin
         posted_credit_recheck     <= pkt_done && counts_move
                                    && done_class == ttu_posted_type_e;
         completion_credit_recheck <= pkt_done && counts_move
                                    && done_class == ttu_completion_type_e;
      end
   end

endmodule

`default_nettype wire
